// ===== rtt_fe_model.sv
// front end stand-in: measurement source and receive frame completion
`default_nettype none
module rtt_fe_model
   import rtt_pkg::*;
(
   // clock
   input wire logic clk,
   // towards the bank
   output rtt_meas_s meas,
   output logic rx_frame_done_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      meas = '0;
      rx_frame_done_pin = 1'b0;
   end
   // level line shows the inverse once the sample is withdrawn
   task send(input logic [7:0] level);
      @(posedge clk);
      meas <= {1'b1, level};
      @(posedge clk);
      meas <= {1'b0, ~level};
   endtask : send
   task frame_done();
      @(posedge clk);
      rx_frame_done_pin <= 1'b1;
      repeat (4) @(posedge clk);
      rx_frame_done_pin <= 1'b0;
   endtask : frame_done
endmodule : rtt_fe_model
`default_nettype wire

// ===== rtt_pkg.sv
// types of the radio tuning and test mode register bank
`default_nettype none
package rtt_pkg;
   typedef enum logic [2:0] {
      RTT_OFF = 3'b000,
      RTT_SETTLE = 3'b001,
      RTT_IDLE = 3'b010,
      RTT_TX = 3'b011,
      RTT_RX = 3'b100
   } rtt_state_e;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [17:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } rtt_wb_req_s;
   typedef struct packed {
      logic valid;
      logic [7:0] level;
   } rtt_meas_s;
endpackage : rtt_pkg
`default_nettype wire

// ===== rtt_regs.svh
// register offsets, reset values and timing figures of the radio tuning bank
`ifndef RTT_REGS_SVH
`define RTT_REGS_SVH
// register indices; byte address is four times the index
`define RTT_IDX_TXPWR 16'h2d3c
`define RTT_IDX_SIGNAL_STRENGTH_OFFSET 16'h2d3d
`define RTT_IDX_ACKTIM 16'h2d46
`define RTT_IDX_TSTMODE 16'h2d68
`define RTT_IDX_IDLEDLY 16'h2d70
`define RTT_IDX_ANTDLY 16'h2d7a
`define RTT_IDX_ANTCON 16'h2d7b
`define RTT_IDX_RF_INIT_DATA 16'h2d7c
`define RTT_IDX_RFCTL 16'h2d80
`define RTT_IDX_TXLEN 16'h2d81
`define RTT_IDX_STATUS 16'h2d82
`define RTT_IDX_THRESH 16'h2d83
// field positions
`define RTT_TST_CONTINUOUS_TX_SEL 0
`define RTT_TST_CARRIER 1
`define RTT_TST_CONTINUOUS_RX_SEL 2
`define RTT_CTL_RFON 0
`define RTT_CTL_OSCON 1
`define RTT_CTL_TXTRG 2
`define RTT_CTL_RXTRG 3
// reset values
`define RTT_RST_SIGNAL_STRENGTH_OFFSET 8'hf6
`define RTT_RST_IDLEDLY 6'h01
`define RTT_RST_ANTDLY 8'h72
`define RTT_RST_ACKTIM 8'h22
`define RTT_RST_TXLEN 8'h05
// timing
`define RTT_CLK_NS 8
`define RTT_SETTLE_UNIT_NS 500000
`define RTT_ANT_STEP_NS 1000
`define RTT_BYTE_NS 32000
`define RTT_SETTLE_UNIT_CYC ((`RTT_SETTLE_UNIT_NS + `RTT_CLK_NS - 1) / `RTT_CLK_NS)
`define RTT_ANT_STEP_CYC (`RTT_ANT_STEP_NS / `RTT_CLK_NS)
`define RTT_BYTE_CYC (`RTT_BYTE_NS / `RTT_CLK_NS)
`endif

// ===== rtt_top.sv
// radio tuning, test mode and antenna switch register bank with its sequencing
`include "rtt_regs.svh"
`default_nettype none
module rtt_top
   import rtt_pkg::*;
#(
   parameter int SETTLE_UNIT_CYC = `RTT_SETTLE_UNIT_CYC
)
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // wishbone slave
   input wire rtt_wb_req_s wb_req,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   // front end measurement and receive status
   input wire rtt_meas_s meas,
   input wire logic rx_frame_done_pin,
   input wire logic auto_ack_en,
   input wire logic port0_pin4_gpio,
   // front end controls
   output logic [4:0] tx_power_level_o,
   output logic carrier_only_sel_o,
   output logic [15:0] rf_init_data_o,
   output logic rf_init_strobe_o,
   output logic [7:0] ack_reply_delay_o,
   output logic [7:0] rssi_result_o,
   output logic rssi_valid_o,
   output logic rx_level_ok_o,
   output logic cca_busy_o,
   output logic [7:0] tx_mem_addr_o,
   output logic tx_active_o,
   output logic rx_active_o,
   output logic idle_event_o,
   output logic port0_pin4
);
   localparam logic [12:0] ANT_STEP = 13'(`RTT_ANT_STEP_CYC);
   localparam logic [12:0] BYTE_CYC = 13'(`RTT_BYTE_CYC);

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [4:0] tx_power_level_r;
   logic [7:0] signal_strength_offset_r;
   logic [7:0] ack_timing_r;
   logic continuous_tx_sel_r;
   logic carrier_only_sel_r;
   logic continuous_rx_sel_r;
   logic [5:0] idle_delay_setting_r;
   logic [7:0] antenna_switch_delay_r;
   logic antenna_switch_output_enable_r;
   logic [7:0] rf_init_low_r;
   logic [15:0] rf_init_data_r;
   logic rf_init_strobe_r;
   logic rf_power_on_request_r;
   logic osc_power_on_request_r;
   logic [7:0] tx_frame_length_r;
   logic [7:0] rx_thresh_r;
   logic [7:0] cca_thresh_r;
   logic tx_trigger_r;
   logic rx_trigger_r;
   logic ack_r;
   logic [31:0] rdata_r;
   rtt_state_e state_r;
   logic antenna_switch_signal_r;

   logic wr;
   logic rd;
   logic [15:0] idx;
   assign idx = wb_req.adr[17:2];
   assign wr = wb_req.cyc & wb_req.stb & wb_req.we & ~ack_r;
   assign rd = wb_req.cyc & wb_req.stb & ~wb_req.we & ~ack_r;

   function automatic logic lane0(input logic [15:0] i, input logic [15:0] want);
      lane0 = (i == want);
   endfunction : lane0

   // ----------------------------------------------------------------
   // bus handshake: one wait-free answer per request
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
         ack_r <= 1'b0;
      else
         ack_r <= wb_req.cyc & wb_req.stb & ~ack_r;
   end

   // ----------------------------------------------------------------
   // configuration writes
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         tx_power_level_r <= 5'h00;
         signal_strength_offset_r <= `RTT_RST_SIGNAL_STRENGTH_OFFSET;
         ack_timing_r <= `RTT_RST_ACKTIM;
         continuous_tx_sel_r <= 1'b0;
         carrier_only_sel_r <= 1'b0;
         continuous_rx_sel_r <= 1'b0;
         idle_delay_setting_r <= `RTT_RST_IDLEDLY;
         antenna_switch_delay_r <= `RTT_RST_ANTDLY;
         antenna_switch_output_enable_r <= 1'b0;
         rf_power_on_request_r <= 1'b0;
         osc_power_on_request_r <= 1'b0;
         tx_frame_length_r <= `RTT_RST_TXLEN;
         rx_thresh_r <= 8'h00;
         cca_thresh_r <= 8'h00;
      end
      else if (wr && wb_req.sel[0])
      begin
         // only assigned bits are stored
         case (idx)
            `RTT_IDX_TXPWR: tx_power_level_r <= wb_req.dat[4:0];
            `RTT_IDX_SIGNAL_STRENGTH_OFFSET: signal_strength_offset_r <= wb_req.dat[7:0];
            `RTT_IDX_ACKTIM: ack_timing_r <= wb_req.dat[7:0];
            `RTT_IDX_TSTMODE:
            begin
               continuous_tx_sel_r <= wb_req.dat[`RTT_TST_CONTINUOUS_TX_SEL];
               carrier_only_sel_r <= wb_req.dat[`RTT_TST_CARRIER];
               continuous_rx_sel_r <= wb_req.dat[`RTT_TST_CONTINUOUS_RX_SEL];
            end
            `RTT_IDX_IDLEDLY: idle_delay_setting_r <= wb_req.dat[5:0];
            `RTT_IDX_ANTDLY: antenna_switch_delay_r <= wb_req.dat[7:0];
            `RTT_IDX_ANTCON: antenna_switch_output_enable_r <= wb_req.dat[0];
            `RTT_IDX_RFCTL:
            begin
               rf_power_on_request_r <= wb_req.dat[`RTT_CTL_RFON];
               osc_power_on_request_r <= wb_req.dat[`RTT_CTL_OSCON];
            end
            `RTT_IDX_TXLEN: tx_frame_length_r <= wb_req.dat[7:0];
            `RTT_IDX_THRESH:
            begin
               rx_thresh_r <= wb_req.dat[7:0];
               if (wb_req.sel[1])
                  cca_thresh_r <= wb_req.dat[15:8];
            end
            default: ;
         endcase
      end
   end

   // triggers are write-one pulses and read back as zero
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         tx_trigger_r <= 1'b0;
         rx_trigger_r <= 1'b0;
      end
      else
      begin
         tx_trigger_r <= wr & wb_req.sel[0] & lane0(idx, `RTT_IDX_RFCTL)
            & wb_req.dat[`RTT_CTL_TXTRG];
         rx_trigger_r <= wr & wb_req.sel[0] & lane0(idx, `RTT_IDX_RFCTL)
            & wb_req.dat[`RTT_CTL_RXTRG];
      end
   end

   // init word: low lane is held, the high lane commits the word
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rf_init_low_r <= 8'h00;
         rf_init_data_r <= 16'h0000;
         rf_init_strobe_r <= 1'b0;
      end
      else if (state_r == RTT_OFF)
      begin
         rf_init_low_r <= 8'h00;
         rf_init_data_r <= 16'h0000;
         rf_init_strobe_r <= 1'b0;
      end
      else
      begin
         rf_init_strobe_r <= 1'b0;
         if (wr && lane0(idx, `RTT_IDX_RF_INIT_DATA))
         begin
            if (wb_req.sel[0])
               rf_init_low_r <= wb_req.dat[7:0];
            if (wb_req.sel[1])
            begin
               rf_init_data_r <= {wb_req.dat[15:8],
                  wb_req.sel[0] ? wb_req.dat[7:0] : rf_init_low_r};
               rf_init_strobe_r <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // sequencing of power-up, transmit and receive
   // ----------------------------------------------------------------
   logic rx_s1_r;
   logic rx_s2_r;
   logic rx_s3_r;
   logic rx_done;
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rx_s1_r <= 1'b0;
         rx_s2_r <= 1'b0;
         rx_s3_r <= 1'b0;
      end
      else
      begin
         rx_s1_r <= rx_frame_done_pin;
         rx_s2_r <= rx_s1_r;
         rx_s3_r <= rx_s2_r;
      end
   end
   assign rx_done = rx_s2_r & ~rx_s3_r;

   logic [31:0] unit_cnt_r;
   logic [5:0] unit_num_r;
   logic [12:0] step_cnt_r;
   logic [7:0] step_num_r;
   logic [7:0] byte_num_r;
   logic idle_event_r;
   logic powered;
   logic [7:0] last_byte;
   assign powered = rf_power_on_request_r | osc_power_on_request_r;
   assign last_byte = tx_frame_length_r - 8'd3;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_r <= RTT_OFF;
         unit_cnt_r <= 32'd0;
         unit_num_r <= 6'd0;
         step_cnt_r <= 13'd0;
         step_num_r <= 8'd0;
         byte_num_r <= 8'd0;
         idle_event_r <= 1'b0;
         antenna_switch_signal_r <= 1'b0;
      end
      else
      begin
         idle_event_r <= 1'b0;
         if (!powered)
         begin
            state_r <= RTT_OFF;
            antenna_switch_signal_r <= 1'b0;
         end
         else
         begin
            case (state_r)
               RTT_OFF:
               begin
                  state_r <= RTT_SETTLE;
                  unit_cnt_r <= 32'd0;
                  unit_num_r <= 6'd0;
               end
               RTT_SETTLE:
               begin
                  if (unit_num_r >= idle_delay_setting_r)
                  begin
                     state_r <= RTT_IDLE;
                     idle_event_r <= 1'b1;
                  end
                  else if (unit_cnt_r == 32'(SETTLE_UNIT_CYC - 1))
                  begin
                     unit_cnt_r <= 32'd0;
                     unit_num_r <= unit_num_r + 6'd1;
                  end
                  else
                     unit_cnt_r <= unit_cnt_r + 32'd1;
               end
               RTT_IDLE:
               begin
                  antenna_switch_signal_r <= 1'b0;
                  step_cnt_r <= 13'd0;
                  step_num_r <= 8'd0;
                  byte_num_r <= 8'd0;
                  if (tx_trigger_r)
                     state_r <= RTT_TX;
                  else if (rx_trigger_r)
                     state_r <= RTT_RX;
               end
               RTT_TX:
               begin
                  if (step_num_r >= antenna_switch_delay_r)
                     antenna_switch_signal_r <= 1'b1;
                  else if (step_cnt_r == ANT_STEP - 13'd1)
                     step_num_r <= step_num_r + 8'd1;
                  if (step_cnt_r == BYTE_CYC - 13'd1)
                  begin
                     step_cnt_r <= 13'd0;
                     if (step_num_r >= antenna_switch_delay_r)
                     begin
                        if (byte_num_r >= last_byte)
                        begin
                           byte_num_r <= 8'd0;
                           if (!continuous_tx_sel_r)
                              state_r <= RTT_IDLE;
                        end
                        else
                           byte_num_r <= byte_num_r + 8'd1;
                     end
                  end
                  else if (step_cnt_r == ANT_STEP - 13'd1 &&
                     step_num_r < antenna_switch_delay_r)
                     step_cnt_r <= 13'd0;
                  else
                     step_cnt_r <= step_cnt_r + 13'd1;
               end
               RTT_RX:
               begin
                  if (rx_done && !continuous_rx_sel_r)
                     state_r <= RTT_IDLE;
               end
               default: state_r <= RTT_OFF;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // measurement offset and threshold compare
   // ----------------------------------------------------------------
   logic [7:0] adj_level;
   assign adj_level = meas.level + signal_strength_offset_r;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rssi_result_o <= 8'h00;
         rssi_valid_o <= 1'b0;
         rx_level_ok_o <= 1'b0;
         cca_busy_o <= 1'b0;
      end
      else
      begin
         rssi_valid_o <= meas.valid;
         if (meas.valid)
         begin
            rssi_result_o <= adj_level;
            rx_level_ok_o <= $signed(adj_level) >= $signed(rx_thresh_r);
            cca_busy_o <= $signed(adj_level) >= $signed(cca_thresh_r);
         end
      end
   end

   // ----------------------------------------------------------------
   // read data and front end outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
         rdata_r <= 32'h0000_0000;
      else if (rd)
      begin
         case (idx)
            `RTT_IDX_TXPWR: rdata_r <= {27'h0, tx_power_level_r};
            `RTT_IDX_SIGNAL_STRENGTH_OFFSET: rdata_r <= {24'h0, signal_strength_offset_r};
            `RTT_IDX_ACKTIM: rdata_r <= {24'h0, ack_timing_r};
            `RTT_IDX_TSTMODE: rdata_r <= {29'h0, continuous_rx_sel_r,
               carrier_only_sel_r, continuous_tx_sel_r};
            `RTT_IDX_IDLEDLY: rdata_r <= {26'h0, idle_delay_setting_r};
            `RTT_IDX_ANTDLY: rdata_r <= {24'h0, antenna_switch_delay_r};
            `RTT_IDX_ANTCON: rdata_r <= {31'h0, antenna_switch_output_enable_r};
            `RTT_IDX_RFCTL: rdata_r <= {30'h0, osc_power_on_request_r,
               rf_power_on_request_r};
            `RTT_IDX_TXLEN: rdata_r <= {24'h0, tx_frame_length_r};
            `RTT_IDX_STATUS: rdata_r <= {20'h0, byte_num_r,
               antenna_switch_signal_r, state_r};
            `RTT_IDX_THRESH: rdata_r <= {16'h0, cca_thresh_r, rx_thresh_r};
            default: rdata_r <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         tx_power_level_o <= 5'h00;
         carrier_only_sel_o <= 1'b0;
         ack_reply_delay_o <= 8'h00;
         tx_mem_addr_o <= 8'h00;
         tx_active_o <= 1'b0;
         rx_active_o <= 1'b0;
         port0_pin4 <= 1'b0;
      end
      else
      begin
         tx_power_level_o <= tx_power_level_r;
         carrier_only_sel_o <= carrier_only_sel_r;
         ack_reply_delay_o <= auto_ack_en ? ack_timing_r : 8'h00;
         tx_mem_addr_o <= byte_num_r;
         tx_active_o <= (state_r == RTT_TX);
         rx_active_o <= (state_r == RTT_RX);
         port0_pin4 <= antenna_switch_output_enable_r ?
            antenna_switch_signal_r : port0_pin4_gpio;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdata_r;
   assign rf_init_data_o = rf_init_data_r;
   assign rf_init_strobe_o = rf_init_strobe_r;
   assign idle_event_o = idle_event_r;
endmodule : rtt_top
`default_nettype wire

// ===== rtt_top_chk.sv
// assertion checker for the radio tuning register bank
`include "rtt_regs.svh"
`default_nettype none
module rtt_top_chk
   import rtt_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // register bus
   input wire rtt_wb_req_s wb_req,
   input wire logic wb_ack_o,
   // front end side
   input wire rtt_meas_s meas,
   input wire logic auto_ack_en,
   input wire logic [4:0] tx_power_level_o,
   input wire logic carrier_only_sel_o,
   input wire logic [7:0] ack_reply_delay_o,
   input wire logic [7:0] rssi_result_o,
   input wire logic rssi_valid_o,
   input wire logic tx_active_o,
   input wire logic rx_active_o,
   input wire logic idle_event_o
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // ------------------------------
   // shadow copies of written values
   // ------------------------------
   logic take;
   logic wr0;
   logic [7:0] ofs_r;
   logic [7:0] ackt_r;
   assign take = wb_req.cyc && wb_req.stb && !wb_ack_o;
   assign wr0 = take && wb_req.we && wb_req.sel[0];
   always_ff @(posedge clk)
   begin
      if (srst)
         ofs_r <= `RTT_RST_SIGNAL_STRENGTH_OFFSET;
      else if (wr0 && wb_req.adr == {`RTT_IDX_SIGNAL_STRENGTH_OFFSET, 2'b00})
         ofs_r <= wb_req.dat[7:0];
   end
   always_ff @(posedge clk)
   begin
      if (srst)
         ackt_r <= `RTT_RST_ACKTIM;
      else if (wr0 && wb_req.adr == {`RTT_IDX_ACKTIM, 2'b00})
         ackt_r <= wb_req.dat[7:0];
   end
   // ------------------------------
   // properties
   // ------------------------------
   sequence s_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   sequence s_not_tx_then_low;
      !tx_active_o ##1 !idle_event_o;
   endsequence
   property p_ack; take |=> s_ack_pulse; endproperty
   property p_ack_src; wb_ack_o |-> $past(take); endproperty
   property p_txpwr;
      wr0 && wb_req.adr == {`RTT_IDX_TXPWR, 2'b00} |=> ##1
         tx_power_level_o == $past(wb_req.dat[4:0], 2);
   endproperty
   property p_carrier;
      wr0 && wb_req.adr == {`RTT_IDX_TSTMODE, 2'b00} |=> ##1
         carrier_only_sel_o == $past(wb_req.dat[1], 2);
   endproperty
   property p_rssi;
      meas.valid |=> rssi_valid_o && rssi_result_o == $past(meas.level) + $past(ofs_r);
   endproperty
   property p_ackdly_on; auto_ack_en |=> ack_reply_delay_o == $past(ackt_r); endproperty
   property p_ackdly_off; !auto_ack_en |=> ack_reply_delay_o == 8'h00; endproperty
   property p_excl; !(tx_active_o && rx_active_o); endproperty
   property p_idle; idle_event_o |-> s_not_tx_then_low; endproperty
   a_ack: assert property (p_ack) else $error("bus ack not a one-cycle answer");
   a_ack_src: assert property (p_ack_src) else $error("bus ack without request");
   a_txpwr: assert property (p_txpwr) else $error("power code not applied");
   a_carrier: assert property (p_carrier) else $error("carrier select wrong");
   a_rssi: assert property (p_rssi) else $error("adjusted level wrong");
   a_ackdly_on: assert property (p_ackdly_on) else $error("ack delay not passed");
   a_ackdly_off: assert property (p_ackdly_off) else $error("ack delay not zero");
   a_excl: assert property (p_excl) else $error("transmit and receive together");
   a_idle: assert property (p_idle) else $error("idle event malformed");
endmodule : rtt_top_chk
bind rtt_top rtt_top_chk rtt_top_chk_inst (.clk, .srst, .wb_req, .wb_ack_o, .meas, .auto_ack_en,
   .tx_power_level_o, .carrier_only_sel_o, .ack_reply_delay_o, .rssi_result_o, .rssi_valid_o,
   .tx_active_o, .rx_active_o, .idle_event_o);
`default_nettype wire

// ===== rtt_unused_guard.sv
// spare unit: holds no logic
`default_nettype none
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the radio tuning register bank
`include "rtt_regs.svh"
`default_nettype none
module tb_top
   import rtt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SU = 20;
   logic clk;
   logic srst;
   rtt_wb_req_s wb_req;
   logic wb_ack_o;
   logic [31:0] wb_dat_o;
   rtt_meas_s meas;
   logic rx_frame_done_pin;
   logic auto_ack_en;
   logic port0_pin4_gpio;
   logic [4:0] tx_power_level_o;
   logic carrier_only_sel_o;
   logic [15:0] rf_init_data_o;
   logic rf_init_strobe_o;
   logic [7:0] ack_reply_delay_o;
   logic [7:0] rssi_result_o;
   logic rssi_valid_o;
   logic rx_level_ok_o;
   logic cca_busy_o;
   logic [7:0] tx_mem_addr_o;
   logic tx_active_o;
   logic rx_active_o;
   logic idle_event_o;
   logic port0_pin4;
   int err_count;
   int comparisons;
   rtt_top #(.SETTLE_UNIT_CYC(SU)) rtt_top_inst (.clk, .srst, .wb_req, .wb_ack_o, .wb_dat_o,
      .meas, .rx_frame_done_pin, .auto_ack_en, .port0_pin4_gpio, .tx_power_level_o,
      .carrier_only_sel_o, .rf_init_data_o, .rf_init_strobe_o, .ack_reply_delay_o,
      .rssi_result_o, .rssi_valid_o, .rx_level_ok_o, .cca_busy_o, .tx_mem_addr_o,
      .tx_active_o, .rx_active_o, .idle_event_o, .port0_pin4);
   rtt_fe_model rtt_fe_model_inst (.clk, .meas, .rx_frame_done_pin);
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // ------------------------------
   // shared tasks
   // ------------------------------
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : chk
   task summarize();
      $display("mismatches %0d, comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : summarize
   task wb(input logic we, input logic [15:0] idx, input logic [3:0] sel,
      input logic [31:0] dat, output logic [31:0] rd);
      int n;
      @(posedge clk);
      wb_req <= {2'b11, we, idx, 2'b00, sel, dat};
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 50);
      rd = wb_dat_o;
      wb_req <= '0;
      chk("bus ack", 32'(n < 50), 32'h1);
   endtask : wb
   task wr(input logic [15:0] idx, input logic [31:0] dat);
      logic [31:0] d;
      wb(1'b1, idx, 4'hf, dat, d);
   endtask : wr
   task rd(input logic [15:0] idx, input logic [31:0] exp);
      logic [31:0] d;
      wb(1'b0, idx, 4'hf, 32'h0, d);
      chk($sformatf("register %h", idx), d, exp);
   endtask : rd
   task power_up(input int lim, output int n);
      wr(`RTT_IDX_RFCTL, 32'h1);
      n = 0;
      while (idle_event_o !== 1'b1 && n < lim)
      begin
         @(posedge clk);
         n++;
      end
   endtask : power_up
   task meas_chk(input logic [7:0] lvl, input logic [7:0] res, input logic ok, input logic busy);
      rtt_fe_model_inst.send(lvl);
      @(negedge clk);
      chk("rssi valid", 32'(rssi_valid_o), 32'h1);
      chk("rssi result", 32'(rssi_result_o), 32'(res));
      chk("rx level", 32'(rx_level_ok_o), 32'(ok));
      chk("cca busy", 32'(cca_busy_o), 32'(busy));
   endtask : meas_chk
   task init_chk(input logic [15:0] exp);
      int n;
      n = 0;
      while (rf_init_strobe_o !== 1'b1 && n < 5)
      begin
         @(posedge clk);
         n++;
      end
      chk("init strobe", 32'(n < 5), 32'h1);
      @(negedge clk);
      chk("init word", 32'(rf_init_data_o), 32'(exp));
   endtask : init_chk
   // ------------------------------
   // scenarios
   // ------------------------------
   task t_reset_vals();
      rd(`RTT_IDX_SIGNAL_STRENGTH_OFFSET, 32'hf6);
      rd(`RTT_IDX_TXPWR, 32'h0);
      rd(`RTT_IDX_ANTDLY, 32'h72);
      rd(`RTT_IDX_IDLEDLY, 32'h1);
      rd(`RTT_IDX_TSTMODE, 32'h0);
      rd(`RTT_IDX_RF_INIT_DATA, 32'h0);
      rd(16'h0000, 32'h0);
   endtask : t_reset_vals
   task t_regs();
      for (int c = 0; c < 32; c++)
      begin
         wr(`RTT_IDX_TXPWR, 32'(c));
         @(negedge clk);
         chk("power code", 32'(tx_power_level_o), 32'(c));
      end
      wr(`RTT_IDX_TXPWR, 32'hff);
      rd(`RTT_IDX_TXPWR, 32'h1f);
      wr(`RTT_IDX_TSTMODE, 32'hfa);
      rd(`RTT_IDX_TSTMODE, 32'h2);
      chk("carrier", 32'(carrier_only_sel_o), 32'h1);
      wr(`RTT_IDX_TSTMODE, 32'h0);
      @(negedge clk);
      chk("carrier", 32'(carrier_only_sel_o), 32'h0);
      wr(`RTT_IDX_ANTCON, 32'hff);
      rd(`RTT_IDX_ANTCON, 32'h1);
      wr(`RTT_IDX_ANTCON, 32'h0);
      wr(`RTT_IDX_IDLEDLY, 32'hff);
      rd(`RTT_IDX_IDLEDLY, 32'h3f);
      wr(`RTT_IDX_ACKTIM, 32'h28);
      @(negedge clk);
      chk("ack delay", 32'(ack_reply_delay_o), 32'h0);
      auto_ack_en <= 1'b1;
      repeat (3) @(posedge clk);
      chk("ack delay", 32'(ack_reply_delay_o), 32'h28);
   endtask : t_regs
   task t_rssi();
      wr(`RTT_IDX_THRESH, 32'hf0e0);
      meas_chk(8'h0a, 8'h00, 1'b1, 1'b1);
      wr(`RTT_IDX_SIGNAL_STRENGTH_OFFSET, 32'hf3);
      meas_chk(8'he6, 8'hd9, 1'b0, 1'b0);
      meas_chk(8'h10, 8'h03, 1'b1, 1'b1);
      meas_chk(8'hed, 8'he0, 1'b1, 1'b0);
   endtask : t_rssi
   task t_power();
      int n;
      logic [31:0] d;
      wr(`RTT_IDX_IDLEDLY, 32'h2);
      power_up(400, n);
      chk("settle time", 32'(n >= 2 * SU - 4 && n <= 2 * SU + 6), 32'h1);
      wb(1'b1, `RTT_IDX_RF_INIT_DATA, 4'h3, 32'h3280, d);
      init_chk(16'h3280);
      repeat (40) @(posedge clk);
      wb(1'b1, `RTT_IDX_RF_INIT_DATA, 4'h1, 32'h0, d);
      wb(1'b1, `RTT_IDX_RF_INIT_DATA, 4'h2, 32'h3200, d);
      init_chk(16'h3200);
      wr(`RTT_IDX_RFCTL, 32'h0);
      repeat (4) @(posedge clk);
      chk("init cleared", 32'(rf_init_data_o), 32'h0);
   endtask : t_power
   task t_tx();
      int n;
      int top;
      int wraps;
      logic all_on;
      logic [7:0] prev;
      wr(`RTT_IDX_IDLEDLY, 32'h1);
      power_up(200, n);
      wr(`RTT_IDX_TXLEN, 32'h5);
      wr(`RTT_IDX_ANTDLY, 32'h2);
      wr(`RTT_IDX_ANTCON, 32'h1);
      wr(`RTT_IDX_TSTMODE, 32'h1);
      wr(`RTT_IDX_RFCTL, 32'h5);
      n = 0;
      while (port0_pin4 !== 1'b1 && n < 1000)
      begin
         @(posedge clk);
         n++;
      end
      chk("antenna delay", 32'(n >= 240 && n <= 270), 32'h1);
      top = 0;
      wraps = 0;
      all_on = 1'b1;
      prev = tx_mem_addr_o;
      repeat (14000)
      begin
         @(posedge clk);
         if (int'(tx_mem_addr_o) > top) top = int'(tx_mem_addr_o);
         if (prev == 8'h2 && tx_mem_addr_o == 8'h0) wraps++;
         if (tx_active_o !== 1'b1) all_on = 1'b0;
         prev = tx_mem_addr_o;
      end
      chk("last byte", 32'(top), 32'h2);
      chk("frame repeats", 32'(wraps > 0), 32'h1);
      chk("tx held", 32'(all_on), 32'h1);
      wr(`RTT_IDX_ANTCON, 32'h0);
      repeat (2) @(posedge clk);
      chk("port pin", 32'(port0_pin4), 32'h0);
      port0_pin4_gpio <= 1'b1;
      repeat (2) @(posedge clk);
      chk("port pin", 32'(port0_pin4), 32'h1);
      wr(`RTT_IDX_RFCTL, 32'h0);
      wr(`RTT_IDX_TSTMODE, 32'h0);
      repeat (4) @(posedge clk);
      chk("tx stopped", 32'(tx_active_o), 32'h0);
   endtask : t_tx
   task t_rx();
      int n;
      power_up(200, n);
      wr(`RTT_IDX_TSTMODE, 32'h4);
      wr(16'h2da6, 32'h1);
      wr(`RTT_IDX_RFCTL, 32'h9);
      repeat (4) @(posedge clk);
      chk("rx active", 32'(rx_active_o), 32'h1);
      rtt_fe_model_inst.frame_done();
      repeat (20) @(posedge clk);
      chk("rx kept", 32'(rx_active_o), 32'h1);
      wr(`RTT_IDX_TSTMODE, 32'h0);
      rtt_fe_model_inst.frame_done();
      repeat (20) @(posedge clk);
      chk("rx ended", 32'(rx_active_o), 32'h0);
      wr(`RTT_IDX_RFCTL, 32'h0);
   endtask : t_rx
   // ------------------------------
   // main sequence and watchdog
   // ------------------------------
   initial
   begin
      srst = 1'b1;
      wb_req = '0;
      auto_ack_en = 1'b0;
      port0_pin4_gpio = 1'b0;
      err_count = 0;
      comparisons = 0;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      t_reset_vals();
      t_regs();
      t_rssi();
      t_power();
      t_tx();
      t_rx();
      summarize();
   end
   initial
   begin
      repeat (60000) @(posedge clk);
      err_count++;
      summarize();
   end
endmodule : tb_top
`default_nettype wire
